// [src/scp_defs.vh]
// register map, field positions, reset values and mode codes of the
// system clock source and prescaler block.
// assumes a 32-bit register port with word-aligned byte offsets.
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// register byte offsets
`define SCP_SYS_CFG_ADDR   8'h00
`define SCP_PLL_CFG_ADDR   8'h04
`define SCP_STATUS_ADDR    8'h08

// system_config_register fields
`define SCP_SEL_LSB        0
`define SCP_SEL_MSB        1

// pll_config_register fields
`define SCP_DIV_LSB        0
`define SCP_DIV_MSB        9
`define SCP_BYPASS_BIT     16
`define SCP_OSC_SRC_BIT    17

// status register fields
`define SCP_ST_CNT_LSB     0
`define SCP_ST_CNT_MSB     9
`define SCP_ST_LEVEL_BIT   16
`define SCP_ST_PLL_EN_BIT  17
`define SCP_ST_SEL_LSB     24
`define SCP_ST_SEL_MSB     25

// clock_source_select codes
`define SCP_SEL_WAKEUP     2'h0
`define SCP_SEL_RESERVED   2'h1
`define SCP_SEL_PLL        2'h2
`define SCP_SEL_DIRECT     2'h3

// reset values
`define SCP_SEL_RESET      2'h0
`define SCP_BYPASS_RESET   1'h0
`define SCP_OSC_SRC_RESET  1'h0
`define SCP_DIV_RESET      10'h000

// synchroniser depth
`define SCP_SYNC_STAGES    2

`endif

// [src/scp_sync.v]
// two-stage synchroniser for a group of asynchronous levels.
// assumes each bit is an independent level from outside i_clk's domain.
`timescale 1ns/10ps

module scp_sync #(
   parameter WIDTH = 1
) (
   input  wire             i_clk,
   input  wire             i_reset_n,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] stage_a; // first stage, read only by stage_b
   reg [WIDTH-1:0] stage_b; // second stage, safe to use

   // ---------------------------------------------------------------
   // two flip-flops per bit
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stage_a <= {WIDTH{1'b0}};
         stage_b <= {WIDTH{1'b0}};
      end else begin
         stage_a <= i_async;
         stage_b <= stage_a;
      end
   end

   assign o_sync = stage_b;

endmodule

// [src/scp_clock_source.v]
// system clock source selection and oscillator prescaler.
// assumes all clock sources arrive as pins sampled on i_clk, and that
// software reaches the registers over a plain strobe port.
// assumes every source pin toggles slower than half of i_clk, since the
// block sees each pin only as a level sampled on i_clk.
// o_sys_clk is therefore a sampled picture of the chosen source, three
// i_clk cycles behind the pin in the pass-through modes.
//
// Summary of operation
// - select 11 passes direct clock input through
// - select 10 with bypass uses divided oscillator
// - divide factor is divider setting plus one
// - factor one passes oscillator with its duty
// - largest divide factor is 1024
// - bypass with factor one acts like direct
// - select 10 without bypass uses pll output
// - select 00 uses the wakeup clock source
`timescale 1ns/10ps
`include "scp_defs.vh"

module scp_clock_source #(
   parameter DIV_WIDTH = 10
) (
   input  wire        i_clk,
   input  wire        i_reset_n,
   input  wire [7:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   input  wire        i_direct_clock_input,
   input  wire        i_crystal_input,
   input  wire        i_internal_clk,
   input  wire        i_wakeup_clk,
   input  wire        i_pll_clk,
   output reg         o_sys_clk,
   output reg         o_pll_enable
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   reg  [1:0]           clock_source_select;    // system clock source
   reg                  vco_bypass;             // 1 selects prescaler path
   reg                  osc_source;             // 0 crystal, 1 internal
   reg  [DIV_WIDTH-1:0] output_divider_setting; // factor minus one
   reg  [DIV_WIDTH-1:0] div_count;              // position in output period
   reg                  div_level;              // divided oscillator level
   reg                  osc_prev;               // previous oscillator sample
   reg                  next_sys_clk;           // selected clock level
   wire [4:0]           pins_sync;              // synchronised clock pins
   wire                 direct_s;               // direct clock input
   wire                 crystal_s;              // crystal input
   wire                 internal_s;             // internal clock source
   wire                 wakeup_s;               // wakeup clock source
   wire                 pll_s;                  // pll output
   wire                 osc_s;                  // chosen oscillator
   wire                 osc_rise;               // oscillator rising edge
   wire                 div_wrap;               // last input period reached
   wire [DIV_WIDTH-1:0] next_count;             // counter after this edge
   wire [DIV_WIDTH:0]   half_period;            // high-phase length in edges
   wire                 prescale_mode;          // prescaler path active
   wire                 next_pll_enable;        // pll wanted

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   scp_sync #(
      .WIDTH (5)
   ) u_sync (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_async   ({i_pll_clk, i_wakeup_clk, i_internal_clk,
                   i_crystal_input, i_direct_clock_input}),
      .o_sync    (pins_sync)
   );

   assign direct_s   = pins_sync[0];
   assign crystal_s  = pins_sync[1];
   assign internal_s = pins_sync[2];
   assign wakeup_s   = pins_sync[3];
   assign pll_s      = pins_sync[4];

   // oscillator feeding the prescaler
   assign osc_s = osc_source ? internal_s : crystal_s;

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         clock_source_select    <= `SCP_SEL_RESET;
         vco_bypass             <= `SCP_BYPASS_RESET;
         osc_source             <= `SCP_OSC_SRC_RESET;
         output_divider_setting <= `SCP_DIV_RESET;
      end else if (i_wr) begin
         case (i_addr)
            `SCP_SYS_CFG_ADDR: begin
               clock_source_select <= i_wdata[`SCP_SEL_MSB:`SCP_SEL_LSB];
            end
            `SCP_PLL_CFG_ADDR: begin
               // full ten-bit field reaches factors 1 through 1024
               output_divider_setting <= i_wdata[`SCP_DIV_MSB:`SCP_DIV_LSB];
               vco_bypass             <= i_wdata[`SCP_BYPASS_BIT];
               osc_source             <= i_wdata[`SCP_OSC_SRC_BIT];
            end
            default: begin
               // unmapped or read-only offsets ignore writes
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // register reads, data one cycle after the strobe
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 32'h00000000;
      end else if (i_rd) begin
         o_rdata <= 32'h00000000;
         case (i_addr)
            `SCP_SYS_CFG_ADDR: begin
               o_rdata[`SCP_SEL_MSB:`SCP_SEL_LSB] <= clock_source_select;
            end
            `SCP_PLL_CFG_ADDR: begin
               o_rdata[`SCP_DIV_MSB:`SCP_DIV_LSB] <= output_divider_setting;
               o_rdata[`SCP_BYPASS_BIT]           <= vco_bypass;
               o_rdata[`SCP_OSC_SRC_BIT]          <= osc_source;
            end
            `SCP_STATUS_ADDR: begin
               o_rdata[`SCP_ST_CNT_MSB:`SCP_ST_CNT_LSB] <= div_count;
               o_rdata[`SCP_ST_LEVEL_BIT]               <= div_level;
               o_rdata[`SCP_ST_PLL_EN_BIT]              <= o_pll_enable;
               o_rdata[`SCP_ST_SEL_MSB:`SCP_ST_SEL_LSB] <= clock_source_select;
            end
            default: begin
               // unmapped offsets read as zero
            end
         endcase
      end else begin
         o_rdata <= 32'h00000000;
      end
   end

   // ---------------------------------------------------------------
   // prescaler: counts oscillator rising edges over factor periods
   // ---------------------------------------------------------------
   // the counter keeps running across a setting change, so the first
   // divided period after a new setting may be short or long; software
   // should let one full period pass before relying on the new rate.
   assign osc_rise    = osc_s & ~osc_prev;
   // wrap at setting, or at once if setting shrank below the count
   assign div_wrap    = (div_count >= output_divider_setting);
   assign next_count  = div_wrap ? {DIV_WIDTH{1'b0}} : div_count + 1'b1;
   // high for the first ceil(factor/2) input periods
   assign half_period = ({1'b0, output_divider_setting} + 2'd2) >> 1;

   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         osc_prev  <= 1'b0;
         div_count <= {DIV_WIDTH{1'b0}};
         div_level <= 1'b0;
      end else begin
         osc_prev <= osc_s;
         if (osc_rise) begin
            div_count <= next_count;
            div_level <= ({1'b0, next_count} < half_period);
         end
      end
   end

   // ---------------------------------------------------------------
   // source selection
   // ---------------------------------------------------------------
   // switching sources is not glitch-free: the new level shows at once,
   // which may cut a high or low phase of the old source short.
   assign prescale_mode   = (clock_source_select == `SCP_SEL_PLL) & vco_bypass;
   assign next_pll_enable = (clock_source_select == `SCP_SEL_PLL) & ~vco_bypass;

   always @* begin
      case (clock_source_select)
         `SCP_SEL_DIRECT: begin
            next_sys_clk = direct_s;
         end
         `SCP_SEL_PLL: begin
            if (prescale_mode) begin
               if (output_divider_setting == {DIV_WIDTH{1'b0}}) begin
                  // factor one: oscillator passes with its own duty
                  next_sys_clk = osc_s;
               end else begin
                  next_sys_clk = div_level;
               end
            end else begin
               next_sys_clk = pll_s;
            end
         end
         `SCP_SEL_WAKEUP: begin
            next_sys_clk = wakeup_s;
         end
         default: begin
            // reserved code holds the clock low
            next_sys_clk = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_sys_clk    <= 1'b0;
         o_pll_enable <= 1'b0;
      end else begin
         o_sys_clk    <= next_sys_clk;
         o_pll_enable <= next_pll_enable;
      end
   end

endmodule

// [dv/scp_clk_model.sv]
// free-running clock sources that stand at the block's clock pins.
// assumes the bench derives its expected periods from these half periods.
`timescale 1ns/10ps
module scp_clk_model #(
   parameter HALF_DIR  = 250,
   parameter HALF_XTAL = 200,
   parameter HALF_INT  = 300,
   parameter HALF_WU   = 350,
   parameter HALF_PLL  = 150
) (
   output reg o_direct,
   output reg o_crystal,
   output reg o_internal,
   output reg o_wakeup,
   output reg o_pll
);
   // ---------------------------------------------------------------
   // sources: offset 37 ns so no edge lands on a bench clock edge
   // ---------------------------------------------------------------
   initial begin
      {o_direct, o_crystal, o_internal, o_wakeup, o_pll} = 5'h00;
      #37;
      fork
         forever #HALF_DIR o_direct = ~o_direct;
         forever #HALF_XTAL o_crystal = ~o_crystal;
         forever #HALF_INT o_internal = ~o_internal;
         forever #HALF_WU o_wakeup = ~o_wakeup;
         forever #HALF_PLL o_pll = ~o_pll;
      join
   end
endmodule

// [dv/scp_monitor.sv]
// checker for the clock source block; shadows the config registers
// from the write port and sees only the top module's ports.
`timescale 1ns/10ps
module scp_monitor #(
   parameter DIV_WIDTH = 10
) (
   input wire        i_clk,
   input wire        i_reset_n,
   input wire [7:0]  i_addr,
   input wire [31:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [31:0] o_rdata,
   input wire        i_direct_clock_input,
   input wire        i_crystal_input,
   input wire        i_internal_clk,
   input wire        i_wakeup_clk,
   input wire        i_pll_clk,
   input wire        o_sys_clk,
   input wire        o_pll_enable
);
   reg [1:0]           sel;  // shadow select
   reg                 byp;  // shadow bypass
   reg                 osc;  // shadow oscillator source
   reg [DIV_WIDTH-1:0] div;  // shadow divider setting
   reg [2:0]           age;  // cycles since the last write, saturating
   wire                calm = (age == 3'h7);
   // ---------------------------------------------------------------
   // shadow registers
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         {sel, byp, osc, div, age} <= 0;
      end else begin
         age <= i_wr ? 3'h0 : (calm ? age : age + 3'h1);
         if (i_wr && i_addr == 8'h00) sel <= i_wdata[1:0];
         if (i_wr && i_addr == 8'h04) {osc, byp, div} <= {i_wdata[17:16], i_wdata[9:0]};
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_direct_pass: assert property (calm && sel == 2'h3
      |-> o_sys_clk == $past(i_direct_clock_input, 3))
      else $error("direct clock not passed");
   a_wakeup_pass: assert property (calm && sel == 2'h0
      |-> o_sys_clk == $past(i_wakeup_clk, 3))
      else $error("wakeup clock not passed");
   a_pll_pass: assert property (calm && sel == 2'h2 && !byp
      |-> o_sys_clk == $past(i_pll_clk, 3))
      else $error("pll clock not passed");
   a_pll_enable: assert property (calm
      |-> o_pll_enable == (sel == 2'h2 && !byp))
      else $error("pll enable wrong");
   a_factor_one: assert property (calm && sel == 2'h2 && byp && div == 0
      |-> o_sys_clk == $past(osc ? i_internal_clk : i_crystal_input, 3))
      else $error("factor one not passed");
   a_reserved_low: assert property (calm && sel == 2'h1
      |-> !o_sys_clk)
      else $error("reserved select not low");
   a_rdata_idle: assert property (!$past(i_rd)
      |-> o_rdata == 32'h00000000)
      else $error("read data not idle");
   a_read_div: assert property ($past(i_rd) && $past(i_addr) == 8'h04
      |-> o_rdata == {14'h0000, $past(osc), $past(byp), 6'h00, $past(div)})
      else $error("divider read wrong");
endmodule
bind scp_clock_source scp_monitor #(
   .DIV_WIDTH (DIV_WIDTH)
) u_mon (
   .i_clk                (i_clk),
   .i_reset_n            (i_reset_n),
   .i_addr               (i_addr),
   .i_wdata              (i_wdata),
   .i_wr                 (i_wr),
   .i_rd                 (i_rd),
   .o_rdata              (o_rdata),
   .i_direct_clock_input (i_direct_clock_input),
   .i_crystal_input      (i_crystal_input),
   .i_internal_clk       (i_internal_clk),
   .i_wakeup_clk         (i_wakeup_clk),
   .i_pll_clk            (i_pll_clk),
   .o_sys_clk            (o_sys_clk),
   .o_pll_enable         (o_pll_enable)
);

// [dv/tb.sv]
// self-checking bench: register port tasks, mode sweep, prescaler corners.
// assumes the clock model's periods of 5, 4, 6, 7 and 3 bench cycles.
`timescale 1ns/10ps
module tb;
   logic        i_clk, i_reset_n, i_wr, i_rd, sysc, plle, cdir, cxt, cint, cwu, cpll;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, rdat, d, w;
   int          bad_count, n_tests, per, hi, s;
   scp_clock_source dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdat), .i_direct_clock_input(cdir),
      .i_crystal_input(cxt), .i_internal_clk(cint), .i_wakeup_clk(cwu), .i_pll_clk(cpll),
      .o_sys_clk(sysc), .o_pll_enable(plle));
   scp_clk_model u_src (.o_direct(cdir), .o_crystal(cxt), .o_internal(cint), .o_wakeup(cwu),
      .o_pll(cpll));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // ---------------------------------------------------------------
   // expectations, compare, bus cycles
   // ---------------------------------------------------------------
   function automatic int per_of(input [1:0] sl, input b, input o, input [9:0] v);
      case (sl)
         2'h0: per_of = 7;
         2'h1: per_of = 0;
         2'h2: per_of = b ? (v + 1) * (o ? 6 : 4) : 3;
         default: per_of = 5;
      endcase
   endfunction
   function automatic int hi_of(input o, input [9:0] v);
      hi_of = (v == 0) ? (o ? 3 : 2) : ((v + 2) / 2) * (o ? 6 : 4);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input [7:0] a, input [31:0] v);
      @(posedge i_clk);
      {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input [7:0] a, output [31:0] v);
      @(posedge i_clk);
      {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = rdat;
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // sets a mode, then times one full period and the high phase of o_sys_clk
   task automatic mode(input [1:0] sl, input b, input o, input [9:0] v);
      int n, k;
      logic last;
      wr(8'h00, {30'h0, sl});
      wr(8'h04, {14'h0, o, b, 6'h00, v});
      repeat (8) @(posedge i_clk);
      #1 {per, hi, k, last} = {32'h0, 32'h0, 32'h0, sysc};
      for (n = 0; n < 9000 && k < 3; n++) begin
         @(posedge i_clk);
         #1 per += (k > 0);
         hi += (k == 1);
         if (sysc !== last) k = (k == 0 && sysc !== 1'b1) ? 0 : k + 1;
         last = sysc;
      end
      if (k < 3 && per_of(sl, b, o, v) != 0) begin
         bad_count++;
         tally_and_finish;
      end
      chk(per, per_of(sl, b, o, v));
      if (b) chk(hi, hi_of(o, v));
      chk(plle, sl == 2'h2 && !b);
      // status shows the select code and the pll request
      rd(8'h08, d);
      chk(d & 32'h03020000, {6'h00, sl, 6'h00, sl == 2'h2 && !b, 17'h00000});
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {i_reset_n, i_wr, i_rd, i_addr, i_wdata, bad_count, n_tests} = 0;
      w = $urandom(32'h3ee422a1);
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      rd(8'h00, d); chk(d, 32'h0);
      rd(8'h04, d); chk(d, 32'h0);
      rd(8'h0C, d); chk(d, 32'h0);
      w = $urandom;
      wr(8'h04, w); rd(8'h04, d); chk(d, w & 32'h000303FF);
      for (s = 0; s < 4; s++) mode(s[1:0], 1'b0, 1'b0, 10'h000);
      mode(2'h2, 1'b1, 1'b0, 10'h000);
      mode(2'h2, 1'b1, 1'b1, 10'h000);
      mode(2'h2, 1'b1, 1'b0, 10'h001);
      mode(2'h2, 1'b1, 1'b1, 10'($urandom) & 10'h1FF);
      mode(2'h2, 1'b1, 1'b0, 10'h3FF);
      // mid-run reset: outputs low while held, fields back to reset values
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk({30'h0, sysc, plle}, 32'h0);
      i_reset_n <= 1'b1;
      rd(8'h00, d);
      chk(d, 32'h0);
      rd(8'h04, d);
      chk(d, 32'h0);
      // the status offset ignores writes
      wr(8'h08, 32'hFFFFFFFF);
      rd(8'h00, d);
      chk(d, 32'h0);
      rd(8'h04, d);
      chk(d, 32'h0);
      tally_and_finish;
   end
endmodule
